// ---- logic/sbp_port.sv ----
`timescale 1ns/1ns
`include "sbp_defs.svh"
// Notes on behaviour
// - An output pin drives its latch bit, unchanged by analog selection.
// - An input pin reads its buffered level unless the pin is analog.
// - After reset pins 2, 5 and 6 are analog inputs.
// - With the reference output on, pin 5 has no digital driver and its level bit reads zero.
// - Pins 3 and 4 are inputs only as port pins, else USB lines.
// - Placement bit 0 puts parallel data 0..2 on pins 7, 6, 5 over direction.
// - Parallel address line five drives pin 2 whatever its direction.
// - With direction 1, pin 7 feeds the serial slave select input.
// - Only bits 7..2 of level, latch and direction exist; 1..0 read zero.
// - Analog-select registers overlay defaults, visible while select bit 4 is 1.
// - Pins 3 and 4 are digital only with the USB disable bit set.
module sbp_port (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register bus, classic single cycle, byte registers in the low lane
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Pads: level seen, value driven, drive enable
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_o,
    output logic      [7:0]  pin_oe_o,
    // Peripherals that may take over pins
    input  wire logic        parallel_address_line_five_i,
    input  wire logic [2:0]  parallel_data_i,
    output logic      [2:0]  parallel_data_o,
    input  wire logic        comparator_one_result_i,
    input  wire logic        usb_dm_o_i,
    input  wire logic        usb_dp_o_i,
    input  wire logic        usb_oe_i,
    // Levels handed back to peripherals
    output logic             serial_slave_select_o,
    output logic             usb_transceiver_disable_o
);
    // ************************************************************
    // Port state
    // ************************************************************
    // All registers in one record; the pad outputs are part of it so that
    // every pin leaves the block straight from a flop
    sbp_pkg::sbp_state_t s_q, s_d;

    // ************************************************************
    // Combinational next state
    // ************************************************************
    // Helpers of the next-state process, each set before it is read
    logic       shared;
    logic [7:0] dig_ok;
    logic [7:0] eff_lo, eff_hi, wv, rv;
    logic       req;
    // One pass computes every next value; each local gets a value before use
    always_comb begin
        s_d    = s_q;
        shared = s_q.wdt[`SBP_SHARED_SEL_BIT];
        req    = wb_cyc_i && wb_stb_i && (s_q.phase == sbp_pkg::SBP_IDLE);
        wv     = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;

        // Digital input qualifier per pin; a cleared select bit keeps the
        // pin analog, and reading it gives zero rather than a floating level
        dig_ok = 8'hFF;
        dig_ok[2] = s_q.asel_lo[`SBP_ASEL_PIN2_BIT];
        dig_ok[5] = s_q.asel_hi[`SBP_ASEL_PIN5_BIT]
                    && !s_q.periph[`SBP_COMPARATOR_REFERENCE_OUT_EN_BIT];
        dig_ok[6] = s_q.asel_hi[`SBP_ASEL_PIN6_BIT];
        dig_ok[3] = s_q.periph[`SBP_USB_DIS_BIT];
        dig_ok[4] = s_q.periph[`SBP_USB_DIS_BIT];

        // Level register; analog or disabled pins read zero
        // One flop of delay, so software sees the pad one cycle late
        s_d.pin_sync = pin_i & dig_ok & `SBP_PORT_MASK;
        s_d.ss_in    = s_q.dir[7] ? pin_i[7] : 1'b1;
        s_d.pmd_in   = {pin_i[5], pin_i[6], pin_i[7]};

        // Pin drive from latch, analog does not gate it
        // The analog path only taps the pad, so the driver stays on
        s_d.pin_out = s_q.latch & `SBP_PORT_MASK;
        s_d.pin_oe  = ~s_q.dir & `SBP_PORT_MASK;

        // USB owns pins 3 and 4 unless disabled; port use is input only
        // Transceiver enable comes from the USB block, never from direction
        if (s_q.periph[`SBP_USB_DIS_BIT]) begin
            s_d.pin_oe[4:3] = 2'b00;
        end else begin
            s_d.pin_out[4:3] = {usb_dp_o_i, usb_dm_o_i};
            s_d.pin_oe[4:3]  = {usb_oe_i, usb_oe_i};
        end

        // Parallel data placement; its own direction bit beats the port's
        // Comparator and reference come later, so they win on pins 7 and 5
        if (!s_q.periph[`SBP_PMP_PLACE_BIT]) begin
            s_d.pin_out[7] = parallel_data_i[0];
            s_d.pin_out[6] = parallel_data_i[1];
            s_d.pin_out[5] = parallel_data_i[2];
            s_d.pin_oe[7:5] = {3{s_q.periph[`SBP_PMP_DIR_BIT]}};
        end

        // Address line five owns pin 2 while in use
        if (s_q.periph[`SBP_PMP_A5_EN_BIT]) begin
            s_d.pin_out[2] = parallel_address_line_five_i;
            s_d.pin_oe[2]  = 1'b1;
        end

        // Comparator result has the last word on pin 7
        if (s_q.periph[`SBP_CMP1_EN_BIT]) begin
            s_d.pin_out[7] = comparator_one_result_i;
            s_d.pin_oe[7]  = 1'b1;
        end

        // Reference output needs the pad free of any digital driver
        if (s_q.periph[`SBP_COMPARATOR_REFERENCE_OUT_EN_BIT]) begin
            s_d.pin_oe[5] = 1'b0;
        end

        // Shared addresses select overlay or default register
        eff_lo = shared ? s_q.asel_lo : s_q.dflt_lo;
        eff_hi = shared ? s_q.asel_hi : s_q.dflt_hi;
        // Read mux; unmapped places read zero
        unique case (wb_adr_i)
            `SBP_PIN_LEVEL_OFF:   rv = s_q.pin_sync;
            `SBP_OUT_LATCH_OFF:   rv = s_q.latch;
            `SBP_DIRECTION_OFF:   rv = s_q.dir;
            `SBP_SHARED_LO_OFF:   rv = eff_lo;
            `SBP_SHARED_HI_OFF:   rv = eff_hi;
            `SBP_WDT_CTRL_OFF:    rv = s_q.wdt;
            `SBP_PERIPH_CTRL_OFF: rv = s_q.periph;
            default:              rv = 8'h00;
        endcase

        // Registered ack: one cycle after the request, dropped the cycle after
        s_d.ack = 1'b0;
        s_d.phase = sbp_pkg::SBP_IDLE;
        if (req) begin
            s_d.ack   = 1'b1;
            s_d.phase = sbp_pkg::SBP_ACK;
            s_d.rdat  = {24'h000000, rv};
            // Writes land at the request edge; only the low byte lane counts
            if (wb_we_i && wb_sel_i[0]) begin
                unique case (wb_adr_i)
                    `SBP_PIN_LEVEL_OFF,
                    `SBP_OUT_LATCH_OFF: s_d.latch = wv & `SBP_PORT_MASK;
                    `SBP_DIRECTION_OFF: s_d.dir = wv & `SBP_PORT_MASK;
                    `SBP_SHARED_LO_OFF: begin
                        if (shared) s_d.asel_lo = wv;
                        else s_d.dflt_lo = wv;
                    end
                    `SBP_SHARED_HI_OFF: begin
                        if (shared) s_d.asel_hi = wv;
                        else s_d.dflt_hi = wv;
                    end
                    `SBP_WDT_CTRL_OFF:    s_d.wdt = wv;
                    `SBP_PERIPH_CTRL_OFF: s_d.periph = wv;
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Synchronous reset; outputs reach their reset values one edge in
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Pins 2, 5, 6 analog, all pins input, USB off, placement one
            s_q         <= '0;
            s_q.latch   <= `SBP_LATCH_RST;
            s_q.dir     <= `SBP_DIR_RST;
            s_q.asel_lo <= `SBP_ASEL_LO_RST;
            s_q.asel_hi <= `SBP_ASEL_HI_RST;
            s_q.periph  <= `SBP_PERIPH_RST;
            s_q.ss_in   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Outputs straight from flops; no gate between register and pin
    assign wb_dat_o                  = s_q.rdat;
    assign wb_ack_o                  = s_q.ack;
    assign pin_o                     = s_q.pin_out;
    assign pin_oe_o                  = s_q.pin_oe;
    assign parallel_data_o           = s_q.pmd_in;
    assign serial_slave_select_o     = s_q.ss_in;
    assign usb_transceiver_disable_o = s_q.periph[`SBP_USB_DIS_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    // Bus handshake
    ack_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read lanes set");
    sel_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !wb_sel_i[0])
        |=> $stable(s_q.latch) && $stable(s_q.dir)) else $error("write without lane");
    ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");

    // Pin drive and read-back
    latch_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!s_q.dir[6] && s_q.periph[`SBP_PMP_PLACE_BIT]) |=> (pin_oe_o[6] && pin_o[6] == $past(s_q.latch[6])))
        else $error("pin6 not driven from latch");
    analog_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_q.asel_lo[`SBP_ASEL_PIN2_BIT] |=> !s_q.pin_sync[2]) else $error("analog pin2 read");
    reset_analog_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> (s_q.asel_hi[3:2] == 2'b00 && !s_q.asel_lo[7])) else $error("reset analog");
    comparator_reference_out_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.periph[`SBP_COMPARATOR_REFERENCE_OUT_EN_BIT] |=> !pin_oe_o[5] && !s_q.pin_sync[5])
        else $error("comparator_reference_out pin5 active");
    usb_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.periph[`SBP_USB_DIS_BIT] |=> pin_oe_o[4:3] == 2'b00) else $error("pin3/4 driven");
    addr_five_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.periph[`SBP_PMP_A5_EN_BIT] |=> pin_oe_o[2]) else $error("pin2 not address");
    low_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.latch[1:0] == 2'b00) && (pin_oe_o[1:0] == 2'b00)) else $error("low bits set");
    cmp_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.periph[`SBP_CMP1_EN_BIT] |=> pin_oe_o[7] && pin_o[7] == $past(comparator_one_result_i))
        else $error("comparator not on pin7");

    // Reset image of direction and peripheral control
    reset_dir_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> (s_q.dir == `SBP_DIR_RST && s_q.periph == `SBP_PERIPH_RST))
        else $error("reset image wrong");

    // Address line five value reaches pin 2
    addr_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.periph[`SBP_PMP_A5_EN_BIT] |=> pin_o[2] == $past(parallel_address_line_five_i))
        else $error("pin2 address value wrong");

    // Parallel data placement on pins 6 and 5, direction from its own bit
    pmd_place_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_q.periph[`SBP_PMP_PLACE_BIT] |=> pin_o[6] == $past(parallel_data_i[1])
        && pin_o[5] == $past(parallel_data_i[2])
        && pin_oe_o[6] == $past(s_q.periph[`SBP_PMP_DIR_BIT]))
        else $error("parallel data not on pins");

    // Parallel data input taken from pins 5, 6 and 7
    pmd_sample_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> parallel_data_o == $past({pin_i[5], pin_i[6], pin_i[7]}))
        else $error("parallel data input wrong");

    // Slave select follows pin 7 while it is an input
    slave_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.dir[7] |=> serial_slave_select_o == $past(pin_i[7]))
        else $error("slave select not from pin7");

    // Closed overlay: a write to the shared low address leaves the selects alone
    overlay_closed_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
         && wb_adr_i == `SBP_SHARED_LO_OFF && !s_q.wdt[`SBP_SHARED_SEL_BIT])
        |=> s_q.asel_lo == $past(s_q.asel_lo))
        else $error("analog select written while hidden");

    // USB owns pins 3 and 4 and blocks their digital read while enabled
    usb_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_q.periph[`SBP_USB_DIS_BIT] |=> pin_oe_o[4:3] == {2{$past(usb_oe_i)}}
        && pin_o[4:3] == $past({usb_dp_o_i, usb_dm_o_i}) && s_q.pin_sync[4:3] == 2'b00)
        else $error("usb pins not under usb");

    // A set select bit lets pin 6 through to the level register
    digital_pin6_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.asel_hi[`SBP_ASEL_PIN6_BIT] |=> s_q.pin_sync[6] == $past(pin_i[6]))
        else $error("digital pin6 not read");

    // Unimplemented low bits of level and direction stay zero
    low_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.pin_sync[1:0] == 2'b00 && s_q.dir[1:0] == 2'b00) else $error("low bits read");

    // Per-pin level path: a pin reads high only if its pad was high
    for (genvar p = 2; p < 8; p++) begin : g_level
        level_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
            1'b1 |=> !s_q.pin_sync[p] || $past(pin_i[p]))
            else $error("level bit without pad level");
    end

    // ************************************************************
    // Coverage
    // ************************************************************
    write_cov_a: cover property (@(posedge clk_i) wb_ack_o && wb_we_i);
    shared_cov_a: cover property (@(posedge clk_i) s_q.wdt[`SBP_SHARED_SEL_BIT] && wb_ack_o);
    pmp_cov_a: cover property (@(posedge clk_i) !s_q.periph[`SBP_PMP_PLACE_BIT]);
    usb_cov_a: cover property (@(posedge clk_i) !s_q.periph[`SBP_USB_DIS_BIT] && pin_oe_o[3]);
    comparator_reference_out_cov_a: cover property (@(posedge clk_i) s_q.periph[`SBP_COMPARATOR_REFERENCE_OUT_EN_BIT]);
endmodule : sbp_port

// ---- pkg/sbp_defs.svh ----
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH
// Register byte offsets
`define SBP_PIN_LEVEL_OFF   6'h00
`define SBP_OUT_LATCH_OFF   6'h04
`define SBP_DIRECTION_OFF   6'h08
`define SBP_SHARED_LO_OFF   6'h0C
`define SBP_SHARED_HI_OFF   6'h10
`define SBP_WDT_CTRL_OFF    6'h14
`define SBP_PERIPH_CTRL_OFF 6'h18
// Field positions
`define SBP_SHARED_SEL_BIT  4
`define SBP_ASEL_PIN2_BIT   7
`define SBP_ASEL_PIN5_BIT   2
`define SBP_ASEL_PIN6_BIT   3
`define SBP_PMP_PLACE_BIT   0
`define SBP_PMP_A5_EN_BIT   1
`define SBP_COMPARATOR_REFERENCE_OUT_EN_BIT    2
`define SBP_CMP1_EN_BIT     3
`define SBP_USB_DIS_BIT     4
`define SBP_PMP_DIR_BIT     5
// Reset values
`define SBP_LATCH_RST       8'h00
`define SBP_DIR_RST         8'hFC
`define SBP_ASEL_LO_RST     8'h00
`define SBP_ASEL_HI_RST     8'h00
`define SBP_PERIPH_RST      8'h11
`define SBP_PORT_MASK       8'hFC
`endif

// ---- pkg/sbp_pkg.sv ----
package sbp_pkg;
    // Bus slave phase
    typedef enum logic [0:0] {
        SBP_IDLE = 1'b0,
        SBP_ACK  = 1'b1
    } sbp_phase_t;

    typedef struct packed {
        sbp_phase_t  phase;
        logic [7:0]  latch;
        logic [7:0]  dir;
        logic [7:0]  asel_lo;
        logic [7:0]  asel_hi;
        logic [7:0]  dflt_lo;
        logic [7:0]  dflt_hi;
        logic [7:0]  wdt;
        logic [7:0]  periph;
        logic [7:0]  pin_sync;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe;
        logic        ss_in;
        logic [2:0]  pmd_in;
        logic [31:0] rdat;
        logic        ack;
    } sbp_state_t;
endpackage : sbp_pkg

// ---- tb/sbp_board.sv ----
`timescale 1ns/1ns
// Board wiring: each pad shows the port's drive where enabled, the board's level elsewhere
module sbp_board (
    input  wire logic [7:0] pad_drive_i,
    input  wire logic [7:0] pad_oe_i,
    input  wire logic [7:0] board_level_i,
    output logic      [7:0] pad_level_o
);
    // Board drives hard, so no pull level needs modelling
    assign pad_level_o = (pad_oe_i & pad_drive_i) | (~pad_oe_i & board_level_i);
endmodule : sbp_board

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`include "sbp_defs.svh"
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        cmp = 1'b0, a5 = 1'b0, ack, ssel, udis;
    logic        udm = 1'b0, udp = 1'b0, uoe = 1'b0;
    logic [3:0]  sel = 4'hF;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h00000000, rd, dat_o;
    logic [7:0]  po, poe, pi, board = 8'h00;
    logic [2:0]  pd = 3'h0, pdo;
    int          err_total = 0, comparisons = 0, lat, dir, per, asl, ash;
    int          per_tab[9] = '{8'h11, 8'h13, 8'h15, 8'h19, 8'h30, 8'h38, 8'h3E, 8'h10, 8'h0B};
    always #5 clk_i = ~clk_i;
    sbp_port uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pin_i(pi), .pin_o(po), .pin_oe_o(poe), .parallel_address_line_five_i(a5),
        .parallel_data_i(pd), .parallel_data_o(pdo), .comparator_one_result_i(cmp),
        .usb_dm_o_i(udm), .usb_dp_o_i(udp), .usb_oe_i(uoe),
        .serial_slave_select_o(ssel), .usb_transceiver_disable_o(udis));
    sbp_board board_m (.pad_drive_i(po), .pad_oe_i(poe), .board_level_i(board), .pad_level_o(pi));
    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle; waits for ack, only the watchdog ends a hang
    task automatic wb(input logic w, input logic [5:0] a, input int d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= 32'(d & 8'hFF);
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // Model of the pads from the register image; overrides as in the port, but address line five taken before placement
    task automatic check_pins;
        logic [7:0] oe, out, w, dig;
        oe = 8'(~dir) & 8'hE4;
        out = lat[7:0];
        if (!per[4]) {oe[4:3], out[4:3]} = {uoe, uoe, udp, udm};
        if (per[1]) {oe[2], out[2]} = {1'b1, a5};
        if (!per[0]) {oe[7:5], out[7:5]} = {{3{per[5]}}, pd[0], pd[1], pd[2]};
        if (per[3]) {oe[7], out[7]} = {1'b1, cmp};
        if (per[2]) oe[5] = 1'b0;
        w = (oe & out) | (~oe & board);
        dig = {1'b1, ash[3] == 1, ash[2] == 1 && !per[2], per[4], per[4], asl[7] == 1, 2'b00};
        chk(32'(poe), 32'(oe));
        chk(32'(po & oe), 32'(out & oe));
        chk(32'(ssel), dir[7] ? 32'(w[7]) : 32'h1);
        chk(32'(pdo), 32'({w[5], w[6], w[7]}));
        wb(1'b0, `SBP_PIN_LEVEL_OFF, 0);
        chk(rd, 32'(w & dig));
    endtask : check_pins
    task automatic stop_test;
        $display("mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    // ****************************************
    // Stimulus
    // ****************************************
    // Watchdog sized well beyond the whole sequence
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h17FD));
        {lat, dir, per, asl, ash} = {32'h0, 32'hFC, 32'h11, 32'h0, 32'h0};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        board <= 8'($urandom);
        wb(1'b0, `SBP_DIRECTION_OFF, 0);
        chk(rd, 32'hFC);
        chk(32'(udis), 32'h1);
        check_pins();
        foreach (per_tab[i]) begin
            if (i == 3) begin
                // Software opens the overlay and makes pins 2, 5, 6 digital
                wb(1'b1, `SBP_WDT_CTRL_OFF, 8'h10);
                {asl, ash} = {32'h80, 32'h0C};
                wb(1'b1, `SBP_SHARED_LO_OFF, asl);
                wb(1'b1, `SBP_SHARED_HI_OFF, ash);
                wb(1'b0, `SBP_SHARED_HI_OFF, 0);
                chk(rd, 32'h0C);
                wb(1'b1, `SBP_WDT_CTRL_OFF, 8'h00);
                wb(1'b0, `SBP_SHARED_LO_OFF, 0);
                chk(rd, 32'h00);
                wb(1'b1, `SBP_SHARED_LO_OFF, 8'h5A);
                wb(1'b0, `SBP_SHARED_LO_OFF, 0);
                chk(rd, 32'h5A);
            end
            {lat, dir, per} = {$urandom & 32'hFF, $urandom & 32'hFF, per_tab[i]};
            board <= 8'($urandom);
            {a5, cmp, pd} <= 5'($urandom);
            {udm, udp, uoe} <= 3'($urandom);
            wb(1'b1, `SBP_OUT_LATCH_OFF, lat);
            wb(1'b1, `SBP_DIRECTION_OFF, dir);
            wb(1'b1, `SBP_PERIPH_CTRL_OFF, per);
            repeat (3) @(posedge clk_i);
            check_pins();
            wb(1'b0, `SBP_OUT_LATCH_OFF, 0);
            chk(rd, 32'(lat & 8'hFC));
            wb(1'b0, `SBP_DIRECTION_OFF, 0);
            chk(rd, 32'(dir & 8'hFC));
        end
        // Unmapped place: write ignored, reads zero
        wb(1'b1, 6'h3C, 8'hFF);
        wb(1'b0, 6'h3C, 0);
        chk(rd, 32'h0);
        // Byte lane off: the write is refused, the latch keeps its value
        sel <= 4'h0;
        wb(1'b1, `SBP_OUT_LATCH_OFF, ~lat);
        sel <= 4'hF;
        wb(1'b0, `SBP_OUT_LATCH_OFF, 0);
        chk(rd, 32'(lat & 8'hFC));
        // Reset again mid-run: pins 2, 5, 6 analog again, all inputs
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        {lat, dir, per, asl, ash} = {32'h0, 32'hFC, 32'h11, 32'h0, 32'h0};
        wb(1'b0, `SBP_DIRECTION_OFF, 0);
        chk(rd, 32'hFC);
        check_pins();
        stop_test();
    end
endmodule : testbench
